// *** clr_ops_regs.svh ***
// Register offsets, field positions, reset values and opcode patterns
`ifndef CLR_OPS_REGS_SVH
`define CLR_OPS_REGS_SVH

// Byte offsets on the register bus
`define OFS_CONTROL 8'h00
`define OFS_BANK_SELECT 8'h04
`define OFS_INDEX_BASE 8'h08
`define OFS_INSTRUCTION 8'h0c
`define OFS_STATUS 8'h10
`define OFS_MEM_ADDR 8'h14
`define OFS_MEM_DATA 8'h18
`define OFS_LAST_TARGET 8'h1c

// Control fields
`define CTRL_EXT_SET_BIT 0
`define CTRL_WATCHDOG_EN_BIT 1

// Status fields
`define STAT_ZERO_BIT 0
`define STAT_TIMEOUT_BIT 1
`define STAT_POWER_DOWN_BIT 2
`define STAT_COUNT_LSB 16

// Reset values
`define RST_CONTROL 2'h0
`define RST_INSTRUCTION 16'hffff

// Instruction encodings
`define OPC_CLEAR_FILE 7'h35
`define OPC_CLEAR_WATCHDOG 16'h0004
`define INDEXED_LIMIT 8'h5f
`define ACCESS_SPLIT 8'h60

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Watchdog timing counts
`define WATCHDOG_PRESCALE_BITS 7
`define WATCHDOG_POSTSCALE_BITS 4

`endif

// *** clr_ops_pkg.sv ***
// Types shared by the clear-register and watchdog-clear decoder
package clr_ops_pkg;

    typedef struct packed {
        logic power_down_flag;
        logic timeout_flag;
        logic zero_flag;
    } status_t;

    typedef struct packed {
        logic clear_file_register_op;
        logic clear_watchdog_op;
        logic access_select;
        logic [7:0] file_operand;
    } decoded_t;

endpackage : clr_ops_pkg

// *** watchdog_core.sv ***
// Watchdog counter with prescaler and postscaler
`timescale 1ns/1ps
module watchdog_core #(
    parameter int PRESCALE_BITS = 7,
    parameter int POSTSCALE_BITS = 4
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control
    input wire logic enable,
    input wire logic clear,
    // State
    output logic [PRESCALE_BITS+POSTSCALE_BITS-1:0] count,
    output logic expired
);
    localparam int W = PRESCALE_BITS + POSTSCALE_BITS;

    generate
        if (PRESCALE_BITS < 1 || POSTSCALE_BITS < 1 || W > 16) begin : g_bad
            $error("watchdog_core: counter widths out of range");
        end
    endgenerate

    logic [W-1:0] next_count;
    logic next_expired;

    ////////////////////////////////////////////////////////////////////////////
    // Clear beats counting, so a clear on the wrap cycle never expires
    always_comb begin
        next_count = count;
        next_expired = 1'b0;
        if (clear) begin
            next_count = '0;
        end else if (enable) begin
            next_count = count + W'(1);
            next_expired = &count;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= '0;
            expired <= 1'b0;
        end else begin
            count <= next_count;
            expired <= next_expired;
        end
    end

endmodule : watchdog_core

// *** clear_register_and_watchdog_ops.sv ***
// Clear-register and watchdog-clear execution behind an AXI4-Lite slave
// Operation
// - Clearing a file register writes zero to the addressed data byte and sets the zero flag.
// - With access-select 0 the file operand is resolved inside the access bank.
// - With access-select 1 the bank select register and file operand form the address.
// - With extended set on, access-select 0 and operand up to 5Fh, indexed offset is used.
`timescale 1ns/1ps
`include "clr_ops_regs.svh"
module clear_register_and_watchdog_ops #(
    parameter int ADDR_WIDTH = 8,
    parameter int BANK_BITS = 4,
    parameter int PRESCALE_BITS = `WATCHDOG_PRESCALE_BITS,
    parameter int POSTSCALE_BITS = `WATCHDOG_POSTSCALE_BITS
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address
    input wire logic [ADDR_WIDTH-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // Write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // Write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // Read address
    input wire logic [ADDR_WIDTH-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // Read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    localparam int MA = BANK_BITS + 8;
    localparam int CW = PRESCALE_BITS + POSTSCALE_BITS;

    generate
        if (ADDR_WIDTH < 8 || BANK_BITS < 1 || BANK_BITS > 8) begin : g_bad
            $error("clear_register_and_watchdog_ops: unsupported widths");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Bus state
    logic [ADDR_WIDTH-1:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic aw_full, next_aw_full, w_full, next_w_full;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;

    // Block state
    logic ext_set_enable, next_ext_set_enable;
    logic watchdog_enable, next_watchdog_enable;
    logic [BANK_BITS-1:0] bank_select_register, next_bank_select_register;
    logic [MA-1:0] index_base, next_index_base;
    logic [15:0] instr_word, next_instr_word;
    clr_ops_pkg::status_t status, next_status;
    logic [MA-1:0] mem_addr, next_mem_addr;
    logic [MA-1:0] last_target, next_last_target;
    logic [7:0] mem [0:(1<<MA)-1];

    // Per-write decode
    logic do_write, wr_mapped, rd_mapped;
    logic [31:0] wmask, merged, rd_value, old_value;
    logic [15:0] new_instr;
    clr_ops_pkg::decoded_t dec;
    logic exec_clear_file, exec_clear_watchdog;
    logic [MA-1:0] target;
    logic mem_we;
    logic [MA-1:0] mem_wa;
    logic [7:0] mem_wd;
    logic [CW-1:0] watchdog_count;
    logic watchdog_expired;

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog
    watchdog_core #(
        .PRESCALE_BITS(PRESCALE_BITS),
        .POSTSCALE_BITS(POSTSCALE_BITS)
    ) u_watchdog (
        .aclk(aclk),
        .aresetn(aresetn),
        .enable(watchdog_enable),
        .clear(exec_clear_watchdog),
        .count(watchdog_count),
        .expired(watchdog_expired)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register read mux
    always_comb begin
        rd_value = 32'h0000_0000;
        rd_mapped = ((araddr >> 8) == '0);
        case ({araddr[7:2], 2'b00})
            `OFS_CONTROL: begin
                rd_value[`CTRL_EXT_SET_BIT] = ext_set_enable;
                rd_value[`CTRL_WATCHDOG_EN_BIT] = watchdog_enable;
            end
            `OFS_BANK_SELECT: rd_value[BANK_BITS-1:0] = bank_select_register;
            `OFS_INDEX_BASE: rd_value[MA-1:0] = index_base;
            `OFS_INSTRUCTION: rd_value[15:0] = instr_word;
            `OFS_STATUS: begin
                rd_value[`STAT_ZERO_BIT] = status.zero_flag;
                rd_value[`STAT_TIMEOUT_BIT] = status.timeout_flag;
                rd_value[`STAT_POWER_DOWN_BIT] = status.power_down_flag;
                rd_value[`STAT_COUNT_LSB +: CW] = watchdog_count;
            end
            `OFS_MEM_ADDR: rd_value[MA-1:0] = mem_addr;
            `OFS_MEM_DATA: rd_value[7:0] = mem[mem_addr];
            `OFS_LAST_TARGET: rd_value[MA-1:0] = last_target;
            default: rd_mapped = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write decode, instruction decode and address resolution
    always_comb begin
        do_write = aw_full && w_full && !bvalid;
        wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
        old_value = {16'h0000, instr_word};
        merged = (old_value & ~wmask) | (w_data & wmask);
        new_instr = merged[15:0];
        wr_mapped = ((aw_addr >> 8) == '0) && (aw_addr[7:5] == 3'b000);
        dec.clear_file_register_op = (new_instr[15:9] == `OPC_CLEAR_FILE);
        dec.clear_watchdog_op = (new_instr == `OPC_CLEAR_WATCHDOG);
        dec.access_select = new_instr[8];
        dec.file_operand = new_instr[7:0];
        exec_clear_file = do_write && ({aw_addr[7:2], 2'b00} == `OFS_INSTRUCTION) && wr_mapped
            && dec.clear_file_register_op;
        exec_clear_watchdog = do_write && ({aw_addr[7:2], 2'b00} == `OFS_INSTRUCTION)
            && wr_mapped && dec.clear_watchdog_op;
        if (dec.access_select) begin
            target = {bank_select_register, dec.file_operand};
        end else if (ext_set_enable && dec.file_operand <= `INDEXED_LIMIT) begin
            target = index_base + {{BANK_BITS{1'b0}}, dec.file_operand};
        end else if (dec.file_operand < `ACCESS_SPLIT) begin
            target = {{BANK_BITS{1'b0}}, dec.file_operand};
        end else begin
            target = {{BANK_BITS{1'b1}}, dec.file_operand};
        end
        // Only one bus write per cycle, so the data port never sees two writers
        mem_we = exec_clear_file
            || (do_write && wr_mapped && {aw_addr[7:2], 2'b00} == `OFS_MEM_DATA && w_strb[0]);
        mem_wa = exec_clear_file ? target : mem_addr;
        mem_wd = exec_clear_file ? 8'h00 : w_data[7:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Block state next values
    always_comb begin
        next_ext_set_enable = ext_set_enable;
        next_watchdog_enable = watchdog_enable;
        next_bank_select_register = bank_select_register;
        next_index_base = index_base;
        next_instr_word = instr_word;
        next_status = status;
        next_mem_addr = mem_addr;
        next_last_target = last_target;
        if (watchdog_expired) begin
            next_status.timeout_flag = 1'b0;
        end
        if (do_write && wr_mapped) begin
            case ({aw_addr[7:2], 2'b00})
                `OFS_CONTROL: if (w_strb[0]) begin
                    next_ext_set_enable = w_data[`CTRL_EXT_SET_BIT];
                    next_watchdog_enable = w_data[`CTRL_WATCHDOG_EN_BIT];
                end
                `OFS_BANK_SELECT: if (w_strb[0]) begin
                    next_bank_select_register = w_data[BANK_BITS-1:0];
                end
                `OFS_INDEX_BASE: next_index_base = merged[MA-1:0] & wmask[MA-1:0]
                    | index_base & ~wmask[MA-1:0];
                `OFS_INSTRUCTION: next_instr_word = new_instr;
                `OFS_STATUS: if (w_strb[0]) begin
                    next_status.zero_flag = w_data[`STAT_ZERO_BIT];
                    next_status.power_down_flag = w_data[`STAT_POWER_DOWN_BIT];
                end
                `OFS_MEM_ADDR: next_mem_addr = (mem_addr & ~wmask[MA-1:0])
                    | (w_data[MA-1:0] & wmask[MA-1:0]);
                default: ;
            endcase
        end
        if (exec_clear_file) begin
            next_status.zero_flag = 1'b1;
            next_last_target = target;
        end
        // The instruction wins over an expiry landing in the same cycle
        if (exec_clear_watchdog) begin
            next_status.timeout_flag = 1'b1;
            next_status.power_down_flag = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_set_enable <= 1'(`RST_CONTROL >> `CTRL_EXT_SET_BIT);
            watchdog_enable <= 1'(`RST_CONTROL >> `CTRL_WATCHDOG_EN_BIT);
            bank_select_register <= '0;
            index_base <= '0;
            instr_word <= `RST_INSTRUCTION;
            status <= 3'b110;
            mem_addr <= '0;
            last_target <= '0;
        end else begin
            ext_set_enable <= next_ext_set_enable;
            watchdog_enable <= next_watchdog_enable;
            bank_select_register <= next_bank_select_register;
            index_base <= next_index_base;
            instr_word <= next_instr_word;
            status <= next_status;
            mem_addr <= next_mem_addr;
            last_target <= next_last_target;
        end
    end

    // Data memory has no reset; contents are undefined until written
    always_ff @(posedge aclk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite handshakes
    always_comb begin
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_aw_full = aw_full;
        next_w_full = w_full;
        next_awready = awready;
        next_wready = wready;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_arready = arready;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (awvalid && awready) begin
            next_aw_addr = awaddr;
            next_aw_full = 1'b1;
            next_awready = 1'b0;
        end
        if (wvalid && wready) begin
            next_w_data = wdata;
            next_w_strb = wstrb;
            next_w_full = 1'b1;
            next_wready = 1'b0;
        end
        if (do_write) begin
            next_bvalid = 1'b1;
            next_bresp = wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
            next_awready = 1'b1;
            next_wready = 1'b1;
        end
        if (arvalid && arready) begin
            next_arready = 1'b0;
            next_rvalid = 1'b1;
            next_rdata = rd_value;
            next_rresp = rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
            next_arready = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr <= '0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            aw_full <= 1'b0;
            w_full <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `RESP_OKAY;
        end else begin
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            arready <= next_arready;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_clear_file_effect;
        @(posedge aclk) disable iff (!aresetn)
        exec_clear_file |=> status.zero_flag && (mem[last_target] == 8'h00);
    endproperty
    a_clear_file_effect: assert property (p_clear_file_effect)
        else $error("cleared register not zero or zero flag not set");

    property p_access_bank;
        @(posedge aclk) disable iff (!aresetn)
        exec_clear_file && !dec.access_select && !(ext_set_enable && dec.file_operand <= 8'h5f)
        |=> (last_target[7:0] == $past(dec.file_operand))
            && (last_target[MA-1:8] == (last_target[7:0] < 8'h60 ? '0 : '1));
    endproperty
    a_access_bank: assert property (p_access_bank)
        else $error("access bank target resolved wrongly");

    property p_banked;
        @(posedge aclk) disable iff (!aresetn)
        exec_clear_file && dec.access_select
        |=> last_target == {$past(bank_select_register), $past(dec.file_operand)};
    endproperty
    a_banked: assert property (p_banked)
        else $error("banked target does not use bank select");

    property p_indexed;
        @(posedge aclk) disable iff (!aresetn)
        exec_clear_file && !dec.access_select && ext_set_enable && dec.file_operand <= 8'h5f
        |=> last_target == MA'($past(index_base) + $past(dec.file_operand));
    endproperty
    a_indexed: assert property (p_indexed)
        else $error("indexed offset target resolved wrongly");

    property p_watchdog_clear;
        @(posedge aclk) disable iff (!aresetn)
        exec_clear_watchdog
        |=> status.timeout_flag && status.power_down_flag && (watchdog_count == '0);
    endproperty
    a_watchdog_clear: assert property (p_watchdog_clear)
        else $error("watchdog clear did not reset counter or set flags");

endmodule : clear_register_and_watchdog_ops

// *** clear_register_and_watchdog_ops_tb.sv ***
// Self-checking testbench for the clear-register and watchdog-clear block
`timescale 1ns/1ps
`include "clr_ops_regs.svh"
module clear_register_and_watchdog_ops_tb;
    ////////////////////////////////////////////////////////////////////////////////////////////
    // Clock, reset and bus signals; every signal the bench drives is given a value at time zero
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic [1:0] rs;

    always #2 aclk = ~aclk;

    // Shortest watchdog so a wrap happens within a few cycles
    clear_register_and_watchdog_ops #(
        .ADDR_WIDTH(8),
        .BANK_BITS(4),
        .PRESCALE_BITS(1),
        .POSTSCALE_BITS(1)
    ) i_dut (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Reporting
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // Hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            $display("MISMATCH timeout expected %h seen %h", 32'h0000_0000, 32'h0000_0001);
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Bus tasks; each waits on the handshake, the timeout ends a hang
    task automatic axi_write(input logic [7:0] addr, input logic [31:0] data,
                             input logic [3:0] strb, input logic [1:0] exp_resp);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        awaddr <= addr;
        awvalid <= 1'b1;
        wdata <= data;
        wstrb <= strb;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && awready === 1'b1) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        check("bresp", {30'h0, exp_resp}, {30'h0, bresp});
    endtask : axi_write

    task automatic axi_read(input logic [7:0] addr, output logic [31:0] data,
                            output logic [1:0] resp);
        @(posedge aclk);
        araddr <= addr;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        data = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : axi_read

    task automatic read_check(input string name, input logic [7:0] addr,
                              input logic [31:0] mask, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(addr, d, r);
        check({name, " rresp"}, 32'h0000_0000, {30'h0, r});
        check(name, exp, d & mask);
    endtask : read_check

    ////////////////////////////////////////////////////////////////////////////////////////////
    // One clear-file case: preload the target byte, execute, look at byte, flag and target
    task automatic run_clear(input logic [1:0] ctrl, input logic [3:0] bank,
                             input logic [11:0] base, input logic acc, input logic [7:0] f,
                             input logic [11:0] exp_addr);
        axi_write(`OFS_CONTROL, {30'h0, ctrl}, 4'h1, `RESP_OKAY);
        axi_write(`OFS_BANK_SELECT, {28'h0, bank}, 4'h1, `RESP_OKAY);
        axi_write(`OFS_INDEX_BASE, {20'h0, base}, 4'hf, `RESP_OKAY);
        axi_write(`OFS_STATUS, 32'h0000_0000, 4'h1, `RESP_OKAY);
        axi_write(`OFS_MEM_ADDR, {20'h0, exp_addr}, 4'hf, `RESP_OKAY);
        axi_write(`OFS_MEM_DATA, 32'h0000_00a5, 4'h1, `RESP_OKAY);
        read_check("zero before", `OFS_STATUS, 32'h0000_0001, 32'h0000_0000);
        axi_write(`OFS_INSTRUCTION, {16'h0, `OPC_CLEAR_FILE, acc, f}, 4'hf, `RESP_OKAY);
        read_check("cleared byte", `OFS_MEM_DATA, 32'h0000_00ff, 32'h0000_0000);
        read_check("zero flag", `OFS_STATUS, 32'h0000_0001, 32'h0000_0001);
        read_check("target", `OFS_LAST_TARGET, 32'h0000_0fff, {20'h0, exp_addr});
        $display("clear-file case a=%0d f=%h done", acc, f);
    endtask : run_clear

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;

        read_check("control reset", `OFS_CONTROL, 32'hffff_ffff, 32'h0000_0000);
        read_check("instr reset", `OFS_INSTRUCTION, 32'hffff_ffff, 32'h0000_ffff);
        read_check("status reset", `OFS_STATUS, 32'h0003_0007, 32'h0000_0006);
        axi_read(8'h20, rd, rs);
        check("unmapped rresp", {30'h0, `RESP_SLVERR}, {30'h0, rs});
        check("unmapped rdata", 32'h0000_0000, rd);
        axi_write(8'h24, 32'h0000_0001, 4'hf, `RESP_SLVERR);
        $display("test reset and map done");

        run_clear(2'h0, 4'h5, 12'h000, 1'b1, 8'h33, 12'h533);
        run_clear(2'h1, 4'ha, 12'h000, 1'b1, 8'h5f, 12'ha5f);
        run_clear(2'h0, 4'h5, 12'h000, 1'b0, 8'h20, 12'h020);
        run_clear(2'h0, 4'h5, 12'h000, 1'b0, 8'h80, 12'hf80);
        run_clear(2'h1, 4'h5, 12'hff0, 1'b0, 8'h5f, 12'h04f);
        run_clear(2'h1, 4'h5, 12'h100, 1'b0, 8'h60, 12'hf60);
        run_clear(2'h1, 4'h5, 12'h100, 1'b0, 8'h00, 12'h100);

        // A word that is neither operation is only stored
        axi_write(`OFS_STATUS, 32'h0000_0000, 4'h1, `RESP_OKAY);
        axi_write(`OFS_INSTRUCTION, 32'h0000_1234, 4'hf, `RESP_OKAY);
        read_check("other word", `OFS_INSTRUCTION, 32'h0000_ffff, 32'h0000_1234);
        read_check("zero kept", `OFS_STATUS, 32'h0000_0001, 32'h0000_0000);
        $display("test other word done");

        // Let the watchdog wrap so the timeout flag drops, freeze it, then clear it
        // Seventeen counting edges leave the count at 1, so the clear is visible
        axi_write(`OFS_CONTROL, 32'h0000_0002, 4'h1, `RESP_OKAY);
        repeat (13) @(posedge aclk);
        axi_write(`OFS_CONTROL, 32'h0000_0000, 4'h1, `RESP_OKAY);
        axi_write(`OFS_STATUS, 32'h0000_0000, 4'h1, `RESP_OKAY);
        read_check("timeout expired", `OFS_STATUS, 32'h0003_0006, 32'h0001_0000);
        axi_write(`OFS_INSTRUCTION, {16'h0, `OPC_CLEAR_WATCHDOG}, 4'hf, `RESP_OKAY);
        read_check("watchdog cleared", `OFS_STATUS, 32'h0003_0006, 32'h0000_0006);
        $display("test watchdog clear done");

        test_done();
    end
endmodule : clear_register_and_watchdog_ops_tb
